//--- src/sas_defs.svh
// Constants for the SAR converter sequencer: timing in converter half-cycles, field codes.
// Assumes it is included by bare name from the package and the design modules.
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

`define SAS_RES_W           10
`define SAS_PRESC_W         8
`define SAS_HALF_W          6
// Sample-and-hold and completion points, in converter half-cycles
`define SAS_SH_NORM         6'h03
`define SAS_DONE_NORM       6'h1a
`define SAS_SH_FIRST        6'h1d
`define SAS_DONE_FIRST      6'h32
`define SAS_SH_AUTO         6'h04
`define SAS_DONE_AUTO       6'h1b
// Trigger code that selects the converter's own completion flag
`define SAS_TRIG_SELF       3'h0
// Channel code fields
`define SAS_DIFF_BIT        4
`define SAS_GAIN20_BIT      0
// Reference codes
`define SAS_REF_AVCC        2'h0
`define SAS_REF_1V1         2'h1
// Reset values, and the SAR start code and bit index loaded at sample-and-hold
`define SAS_SEL_RESET       8'h00
`define SAS_BYTE_RESET      8'h00
`define SAS_DAC_RESET       10'h000
`define SAS_DAC_MID         10'h200
`define SAS_BIT_TOP         4'h9

`endif

//--- src/sas_pkg.sv
// Types shared by the SAR converter sequencer modules.
// Assumes nothing beyond the constants header.
`include "sas_defs.svh"

package sas_pkg;
	typedef struct packed {
		logic [1:0] reference_select;
		logic       ext_ref_pin_enable;
		logic [4:0] channel_gain_select;
	} sas_select_t;

	typedef struct packed {
		logic ref_avcc;
		logic ref_pin;
		logic ref_1v1;
		logic ref_2v56;
	} sas_ref_t;

	typedef enum logic {SAS_IDLE, SAS_CONV} sas_state_t;
endpackage

//--- src/sas_prescaler.sv
// Converter clock prescaler: rise and fall pulses of the divided clock.
// Assumes clk_sys and a synchronous active-high reset; restart is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

module sas_prescaler #(
	parameter int CNT_W = `SAS_PRESC_W
) (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       enable,
	input  wire logic       restart,
	input  wire logic [2:0] prescale_select,
	output logic            rise_pulse,
	output logic            fall_pulse
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             rise_reg;
	logic             rise_next;
	logic             fall_reg;
	logic             fall_next;
	logic [CNT_W-1:0] ratio_m1;
	logic [CNT_W-1:0] half_m1;
	logic [2:0]       shift;

	// Ratio is two to the select, never below two so both edges exist
	always_comb begin
		shift = (prescale_select == 3'h0) ? 3'h1 : prescale_select;
		ratio_m1 = (CNT_W'(1) << shift) - CNT_W'(1);
		half_m1 = (CNT_W'(1) << (shift - 3'h1)) - CNT_W'(1);
		cnt_next = (cnt_reg == ratio_m1) ? '0 : cnt_reg + CNT_W'(1);
		rise_next = enable && !restart && (cnt_reg == ratio_m1);
		fall_next = enable && !restart && (cnt_reg == half_m1);
		if (!enable || restart) begin
			cnt_next = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_reg <= '0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end

	assign rise_pulse = rise_reg;
	assign fall_pulse = fall_reg;
endmodule
`default_nettype wire

//--- src/sas_adc_seq.sv
// SAR converter sequencer: start control, timing, SAR stepping, result bytes, select buffer.
// Assumes all control inputs are clk_sys logic except trigger_in; comparator_in is valid
// on clk_sys and reads one when the input is at or above dac_code.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

// Operation
// - Selections apply only while converter enabled
// - Result right-aligned, left-aligned when bit set
// - Low read locks result bytes until high read
// - Completion flag set even when result discarded
// - Start bit begins conversion, reads busy
// - Channel change waits for current conversion
// - Trigger rising edge restarts prescaler, starts conversion
// - Edges during conversion ignored, no level restart
// - Trigger flag cleared by software before retrigger
// - Own completion flag as trigger: free running
// - Start bit works while auto triggering
// - Prescaler runs while enabled, reset otherwise
// - Clock divided by selectable power-of-two ratio
// - Software start waits next converter clock rise
// - Thirteen cycles normal, twenty-five first conversion
// - Hold at 1.5 or 14.5 cycles
// - Completion writes result, sets flag, clears start
// - Auto hold two cycles after trigger edge
// - Free running restarts at once, start stays high
// - Channel code selects single-ended or gain path
// - Reference from supply, pin or internal
// - Select buffer frozen until last cycle
// - Auto-triggered conversion takes 13.5 cycles
module sas_adc_seq #(
	parameter int N_TRIG = 8
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                converter_enable,
	input  wire logic                start_conversion_write,
	input  wire logic                auto_trigger_enable,
	input  wire logic [2:0]          trigger_source_select,
	input  wire logic [N_TRIG-1:0]   trigger_in,
	input  wire logic [2:0]          prescale_select,
	input  wire sas_pkg::sas_select_t select_in,
	input  wire logic                result_left_align,
	input  wire logic                result_low_read,
	input  wire logic                result_high_read,
	input  wire logic                done_flag_clear,
	input  wire logic                comparator_in,
	output sas_pkg::sas_select_t     applied_select,
	output sas_pkg::sas_ref_t        reference_route,
	output logic                     gain_bypass,
	output logic                     gain_20x,
	output logic                     sample_hold,
	output logic [`SAS_RES_W-1:0]    dac_code,
	output logic [7:0]               result_high_byte,
	output logic [7:0]               result_low_byte,
	output logic                     start_conversion,
	output logic                     conversion_done_flag
);
	// Trigger synchronisers: three flops, level accepted when second and third agree
	logic [N_TRIG-1:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
	logic [N_TRIG-1:0] filt_next;
	genvar gi;
	generate
		for (gi = 0; gi < N_TRIG; gi++) begin : g_sync
			always_comb begin
				filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
			end
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
					filt_reg[gi] <= 1'b0;
					prev_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= trigger_in[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					filt_reg[gi] <= filt_next[gi];
					prev_reg[gi] <= filt_reg[gi];
				end
			end
		end
	endgenerate

	sas_pkg::sas_state_t      state_reg, state_next;
	sas_pkg::sas_select_t     sel_reg, sel_next;
	sas_pkg::sas_ref_t        ref_reg, ref_next;
	logic                     pend_reg, pend_next;
	logic                     first_reg, first_next;
	logic [`SAS_HALF_W-1:0]   half_reg, half_next;
	logic [`SAS_HALF_W-1:0]   sh_tgt_reg, sh_tgt_next;
	logic [`SAS_HALF_W-1:0]   done_tgt_reg, done_tgt_next;
	logic                     start_reg, start_next;
	logic                     hold_reg, hold_next;
	logic [`SAS_RES_W-1:0]    dac_reg, dac_next;
	logic [3:0]               idx_reg, idx_next;
	logic                     act_reg, act_next;
	logic                     flag_reg, flag_next;
	logic                     lock_reg, lock_next;
	logic [7:0]               hi_reg, hi_next;
	logic [7:0]               lo_reg, lo_next;
	logic                     bypass_reg, bypass_next;
	logic                     g20_reg, g20_next;

	logic rise_p, fall_p, edge_p, conv, free_run, trig_edge;
	logic done_ev, hold_ev, unlock_win, auto_start, sw_start, free_start;
	logic [`SAS_HALF_W-1:0] half_inc;

	always_comb begin
		conv = (state_reg == sas_pkg::SAS_CONV);
		edge_p = rise_p || fall_p;
		half_inc = half_reg + `SAS_HALF_W'(1);
		free_run = auto_trigger_enable && (trigger_source_select == `SAS_TRIG_SELF);
		// Level alone never starts; only a fresh edge on the filtered flag
		trig_edge = auto_trigger_enable && !free_run &&
			filt_reg[trigger_source_select] && !prev_reg[trigger_source_select];
		done_ev = conv && edge_p && (half_inc == done_tgt_reg);
		hold_ev = conv && edge_p && (half_inc == sh_tgt_reg);
		unlock_win = conv && ((half_reg + `SAS_HALF_W'(2)) >= done_tgt_reg);
		auto_start = converter_enable && !conv && trig_edge;
		sw_start = converter_enable && !conv && pend_reg && rise_p && !auto_start;
		free_start = converter_enable && done_ev && free_run;
	end

	sas_prescaler #(
		.CNT_W(`SAS_PRESC_W)
	) u_presc (
		.clk_sys        (clk_sys),
		.reset          (reset),
		.enable         (converter_enable),
		.restart        (auto_start),
		.prescale_select(prescale_select),
		.rise_pulse     (rise_p),
		.fall_pulse     (fall_p)
	);

	always_comb begin
		state_next = state_reg;
		sel_next = sel_reg;
		pend_next = pend_reg;
		first_next = first_reg;
		half_next = half_reg;
		sh_tgt_next = sh_tgt_reg;
		done_tgt_next = done_tgt_reg;
		start_next = start_reg;
		hold_next = hold_reg;
		dac_next = dac_reg;
		idx_next = idx_reg;
		act_next = act_reg;
		flag_next = flag_reg;
		lock_next = lock_reg;
		hi_next = hi_reg;
		lo_next = lo_reg;

		if (start_conversion_write && converter_enable && !conv) begin
			pend_next = 1'b1;
			start_next = 1'b1;
		end
		// Buffer follows software only outside the protected part of a conversion
		if (converter_enable && (!conv || unlock_win)) begin
			sel_next = select_in;
		end
		if (conv && edge_p) begin
			half_next = half_inc;
		end
		if (hold_ev) begin
			hold_next = 1'b1;
			dac_next = `SAS_DAC_MID;
			idx_next = `SAS_BIT_TOP;
			act_next = 1'b1;
		end else if (conv && rise_p && act_reg) begin
			if (!comparator_in) begin
				dac_next[idx_reg] = 1'b0;
			end
			if (idx_reg != 4'h0) begin
				dac_next[idx_reg - 4'h1] = 1'b1;
				idx_next = idx_reg - 4'h1;
			end else begin
				act_next = 1'b0;
			end
		end
		if (result_low_read) begin
			lock_next = 1'b1;
		end
		if (result_high_read) begin
			lock_next = 1'b0;
		end
		if (done_flag_clear) begin
			flag_next = 1'b0;
		end
		if (done_ev) begin
			flag_next = 1'b1;
			state_next = sas_pkg::SAS_IDLE;
			start_next = 1'b0;
			hold_next = 1'b0;
			act_next = 1'b0;
			if (!lock_reg) begin
				if (result_left_align) begin
					hi_next = dac_reg[9:2];
					lo_next = {dac_reg[1:0], 6'h00};
				end else begin
					hi_next = {6'h00, dac_reg[9:8]};
					lo_next = dac_reg[7:0];
				end
			end
		end
		if (sw_start || auto_start || free_start) begin
			state_next = sas_pkg::SAS_CONV;
			pend_next = 1'b0;
			start_next = 1'b1;
			half_next = '0;
			hold_next = 1'b0;
			first_next = 1'b0;
			if (auto_start) begin
				sh_tgt_next = `SAS_SH_AUTO;
				done_tgt_next = `SAS_DONE_AUTO;
			end else if (first_reg) begin
				sh_tgt_next = `SAS_SH_FIRST;
				done_tgt_next = `SAS_DONE_FIRST;
			end else begin
				sh_tgt_next = `SAS_SH_NORM;
				done_tgt_next = `SAS_DONE_NORM;
			end
		end
		// Disabling aborts any conversion; the next one is a first conversion again
		if (!converter_enable) begin
			state_next = sas_pkg::SAS_IDLE;
			pend_next = 1'b0;
			start_next = 1'b0;
			hold_next = 1'b0;
			act_next = 1'b0;
			first_next = 1'b1;
		end

		bypass_next = !sel_next.channel_gain_select[`SAS_DIFF_BIT];
		g20_next = sel_next.channel_gain_select[`SAS_DIFF_BIT] &&
			sel_next.channel_gain_select[`SAS_GAIN20_BIT];
		ref_next = '0;
		if (sel_next.ext_ref_pin_enable) begin
			ref_next.ref_pin = 1'b1;
		end else if (sel_next.reference_select == `SAS_REF_AVCC) begin
			ref_next.ref_avcc = 1'b1;
		end else if (sel_next.reference_select == `SAS_REF_1V1) begin
			ref_next.ref_1v1 = 1'b1;
		end else begin
			ref_next.ref_2v56 = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= sas_pkg::SAS_IDLE;
			sel_reg <= `SAS_SEL_RESET;
			ref_reg <= '0;
			pend_reg <= 1'b0;
			first_reg <= 1'b1;
			half_reg <= '0;
			sh_tgt_reg <= `SAS_SH_NORM;
			done_tgt_reg <= `SAS_DONE_NORM;
			start_reg <= 1'b0;
			hold_reg <= 1'b0;
			dac_reg <= `SAS_DAC_RESET;
			idx_reg <= 4'h0;
			act_reg <= 1'b0;
			flag_reg <= 1'b0;
			lock_reg <= 1'b0;
			hi_reg <= `SAS_BYTE_RESET;
			lo_reg <= `SAS_BYTE_RESET;
			bypass_reg <= 1'b0;
			g20_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sel_reg <= sel_next;
			ref_reg <= ref_next;
			pend_reg <= pend_next;
			first_reg <= first_next;
			half_reg <= half_next;
			sh_tgt_reg <= sh_tgt_next;
			done_tgt_reg <= done_tgt_next;
			start_reg <= start_next;
			hold_reg <= hold_next;
			dac_reg <= dac_next;
			idx_reg <= idx_next;
			act_reg <= act_next;
			flag_reg <= flag_next;
			lock_reg <= lock_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
			bypass_reg <= bypass_next;
			g20_reg <= g20_next;
		end
	end

	assign applied_select = sel_reg;
	assign reference_route = ref_reg;
	assign gain_bypass = bypass_reg;
	assign gain_20x = g20_reg;
	assign sample_hold = hold_reg;
	assign dac_code = dac_reg;
	assign result_high_byte = hi_reg;
	assign result_low_byte = lo_reg;
	assign start_conversion = start_reg;
	assign conversion_done_flag = flag_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sel_frozen_a: assert property (conv && !unlock_win |=> $stable(sel_reg))
		else $error("selection changed mid conversion");
	disabled_hold_a: assert property (!converter_enable |=> $stable(sel_reg))
		else $error("selection applied while disabled");
	align_a: assert property (done_ev && !lock_reg && result_left_align |=>
		hi_reg == $past(dac_reg[9:2]) && lo_reg[5:0] == 6'h00)
		else $error("left alignment wrong");
	lock_hold_a: assert property (lock_reg && !result_high_read |=>
		$stable(hi_reg) && $stable(lo_reg))
		else $error("locked result changed");
	flag_set_a: assert property (done_ev |=> flag_reg)
		else $error("completion flag not set");
	busy_read_a: assert property (conv |-> start_reg)
		else $error("start bit low during conversion");
	presc_held_a: assert property (!converter_enable |=> !rise_p && !fall_p)
		else $error("prescaler ran while disabled");
	hold_point_a: assert property ($rose(hold_reg) |-> $past(half_reg) + 6'h01 == sh_tgt_reg)
		else $error("sample-and-hold at wrong point");
	free_run_a: assert property (done_ev && free_run && converter_enable |=>
		conv && start_reg && half_reg == 6'h00)
		else $error("free running did not restart");
	no_retrig_a: assert property (conv && trig_edge |=> !conv || half_reg >= $past(half_reg))
		else $error("trigger accepted during conversion");
	sw_wait_a: assert property (pend_reg && !conv && !rise_p && !auto_start |=> !conv)
		else $error("software start before converter edge");

	first_done_c: cover property (done_ev && done_tgt_reg == `SAS_DONE_FIRST);
	auto_done_c: cover property (done_ev && done_tgt_reg == `SAS_DONE_AUTO);
	discard_c: cover property (done_ev && lock_reg);
	free_run_c: cover property (free_start ##[1:400] free_start);
endmodule
`default_nettype wire

//--- sim/sas_analog_model.sv
// Far-side analog model: comparator of a held input level against the trial code.
// Assumes the bench sets the level before a conversion; answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module sas_analog_model (
	input  wire logic [9:0] analog_level,
	input  wire logic [9:0] dac_code,
	output logic            comparator_in
);
	// Ideal comparator, no offset, so the result equals the level
	assign comparator_in = (analog_level >= dac_code);
endmodule

`default_nettype wire

//--- sim/tb.sv
// Bench for the SAR converter sequencer: timing, results, locking, triggers, selection.
// Assumes the analog model above on the comparator; all inputs driven at rising edges.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                 clk_sys, reset, en, sw_start, auto_en, lo_rd, hi_rd, flag_clr;
	logic                 left, cmp, sh, busy, flag, byp, g20, prev_sh;
	logic [2:0]           trig_sel, psel;
	logic [7:0]           trig, hb, lb;
	logic [9:0]           level, dac;
	logic [15:0]          lfsr, exp_b;
	sas_pkg::sas_select_t sel, app, old_sel;
	sas_pkg::sas_ref_t    rref;
	int                   fails, n_compared, th, td, r, n, lows, cycle, t0;

	sas_adc_seq sas_adc_seq_inst (.clk_sys(clk_sys), .reset(reset), .converter_enable(en),
		.start_conversion_write(sw_start), .auto_trigger_enable(auto_en),
		.trigger_source_select(trig_sel), .trigger_in(trig), .prescale_select(psel),
		.select_in(sel), .result_left_align(left), .result_low_read(lo_rd),
		.result_high_read(hi_rd), .done_flag_clear(flag_clr), .comparator_in(cmp),
		.applied_select(app), .reference_route(rref), .gain_bypass(byp), .gain_20x(g20),
		.sample_hold(sh), .dac_code(dac), .result_high_byte(hb), .result_low_byte(lb),
		.start_conversion(busy), .conversion_done_flag(flag));

	sas_analog_model sas_analog_model_inst (.analog_level(level), .dac_code(dac),
		.comparator_in(cmp));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cycle <= cycle + 1;

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [15:0] exp_bytes(input logic [9:0] v, input logic l);
		return l ? {v, 6'h00} : {6'h00, v};
	endfunction

	// {avcc, pin, 1v1, 2v56, bypass, 20x}
	function automatic logic [5:0] exp_route(input sas_pkg::sas_select_t s);
		logic [3:0] rt;
		rt = s.ext_ref_pin_enable ? 4'h4 : (s.reference_select == 2'h0) ? 4'h8 :
			(s.reference_select == 2'h1) ? 4'h2 : 4'h1;
		return {rt, !s.channel_gain_select[4], s.channel_gain_select[4] & s.channel_gain_select[0]};
	endfunction

	function automatic int ratio_of(input logic [2:0] s);
		return (s == 3'h0) ? 2 : (1 << s);
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_win(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			fails++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Software start; window slack covers the wait for the next converter rise
	task automatic convert(input bit first, input int rr);
		@(posedge clk_sys);
		flag_clr <= 1'b1;
		@(posedge clk_sys);
		flag_clr <= 1'b0;
		sw_start <= 1'b1;
		@(posedge clk_sys);
		sw_start <= 1'b0;
		td = 0;
		th = 0;
		@(negedge clk_sys);
		chk("busy", 16'h1, {15'h0, busy});
		while (flag !== 1'b1 && td < 3000) begin
			@(negedge clk_sys);
			td++;
			if (sh === 1'b1 && th == 0) th = td;
		end
		chk("busy end", 16'h0, {15'h0, busy});
		chk_win("hold", (first ? 29 : 3) * rr / 2 - 1, (first ? 29 : 3) * rr / 2 + rr + 4, th);
		chk_win("done", (first ? 50 : 26) * rr / 2 - 1, (first ? 50 : 26) * rr / 2 + rr + 4, td);
	endtask

	initial begin
		#1200000;
		fails++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		{reset, en, sw_start, auto_en, lo_rd, hi_rd, flag_clr, left} = 8'h80;
		trig_sel = 3'h1;
		psel = 3'h0;
		trig = 8'h00;
		level = 10'h000;
		cycle = 0;
		lfsr = 16'h69a2;
		sel = lfsr[7:0];
		cyc(4);
		reset <= 1'b0;
		@(negedge clk_sys);
		chk("reset bytes", 16'h0, {hb, lb});
		chk("reset ctl", 16'h0, {app, busy, flag, sh, 5'h00});
		cyc(3);
		@(negedge clk_sys);
		chk("gated sel", 16'h0, {8'h00, app});
		$display("test reset done");
		@(posedge clk_sys);
		en <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk_sys);
			sel <= {i[1:0], i == 5, i[2], lfsr[3:1], i[0]};
			cyc(3);
			@(negedge clk_sys);
			chk("applied", {8'h00, sel}, {8'h00, app});
			chk("route", {10'h000, exp_route(sel)}, {10'h000, rref, byp, g20});
		end
		$display("test select done");
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys);
			en <= 1'b0;
			psel <= (k % 3 == 0) ? 3'h0 : (k % 3 == 1) ? 3'h2 : 3'h3;
			left <= k[0];
			@(posedge clk_sys);
			en <= 1'b1;
			r = ratio_of(psel);
			for (int j = 0; j < 2; j++) begin
				lfsr = lfsr_next(lfsr);
				level <= (k == 0) ? 10'h3ff : (k == 1 && j == 1) ? 10'h000 : lfsr[9:0];
				convert(j == 0, r);
				chk("bytes", exp_bytes(level, left), {hb, lb});
				chk("flag", 16'h1, {15'h0, flag});
			end
		end
		$display("test timing done");
		@(posedge clk_sys);
		lo_rd <= 1'b1;
		@(posedge clk_sys);
		lo_rd <= 1'b0;
		exp_b = exp_bytes(level, left);
		level <= ~level;
		convert(0, r);
		chk("locked", exp_b, {hb, lb});
		chk("flag locked", 16'h1, {15'h0, flag});
		@(posedge clk_sys);
		hi_rd <= 1'b1;
		@(posedge clk_sys);
		hi_rd <= 1'b0;
		convert(0, r);
		chk("unlocked", exp_bytes(level, left), {hb, lb});
		$display("test lock done");
		@(posedge clk_sys);
		auto_en <= 1'b1;
		flag_clr <= 1'b1;
		@(posedge clk_sys);
		flag_clr <= 1'b0;
		trig[1] <= 1'b1;
		t0 = cycle;
		while (sh !== 1'b1 && cycle - t0 < 300) @(negedge clk_sys);
		chk_win("auto hold", 2 * r + 3, 3 * r + 8, cycle - t0);
		old_sel = app;
		lfsr = lfsr_next(lfsr);
		@(posedge clk_sys);
		trig[1] <= 1'b0;
		sel <= {lfsr[15:9], ~old_sel[0]};
		cyc(2);
		trig[1] <= 1'b1;
		@(negedge clk_sys);
		chk("frozen sel", {8'h00, old_sel}, {8'h00, app});
		while (flag !== 1'b1 && cycle - t0 < 600) @(negedge clk_sys);
		chk_win("auto done", 27 * r / 2 + 3, 27 * r / 2 + r + 8, cycle - t0);
		cyc(40);
		@(negedge clk_sys);
		chk("no retrigger", 16'h0, {15'h0, busy});
		chk("new sel", {8'h00, sel}, {8'h00, app});
		@(posedge clk_sys);
		trig[1] <= 1'b0;
		cyc(2);
		trig[1] <= 1'b1;
		cyc(12);
		@(negedge clk_sys);
		chk("retrigger", 16'h1, {15'h0, busy});
		while (busy !== 1'b0 && cycle - t0 < 2000) @(negedge clk_sys);
		convert(0, r);
		$display("test trigger done");
		@(posedge clk_sys);
		trig_sel <= 3'h0;
		sw_start <= 1'b1;
		@(posedge clk_sys);
		sw_start <= 1'b0;
		cyc(2);
		n = 0;
		lows = 0;
		prev_sh = sh;
		repeat (40 * r) begin
			@(negedge clk_sys);
			if (sh === 1'b1 && prev_sh === 1'b0) n++;
			if (busy !== 1'b1) lows++;
			prev_sh = sh;
		end
		chk_win("free runs", 2, 4, n);
		chk("free busy", 16'h0, 16'(lows));
		@(posedge clk_sys);
		en <= 1'b0;
		cyc(3);
		@(negedge clk_sys);
		chk("abort", 16'h0, {15'h0, busy});
		$display("test free running done");
		complete_run();
	end
endmodule

`default_nettype wire
